// file: ccr_pkg.sv
// Package for the clock and regulator control registers
package ccr_pkg;
  localparam logic [15:0] ADDR_CLK_OSC  = 16'hff00;
  localparam logic [15:0] ADDR_SUPPLY   = 16'hff01;
  localparam int          BIT_CPU_CLK   = 3;
  localparam int          BIT_FAST_OSC  = 2;
  localparam int          BIT_CORE_VSEL = 0;
  localparam int          BIT_ADC_SRC   = 3;
  localparam int          BIT_REG_SRC   = 2;
  localparam int          BIT_DOUBLER   = 0;
  localparam logic [3:0]  RW_MASK       = 4'hd;
  localparam logic [3:0]  RESET_VALUE   = 4'h0;
  localparam logic [1:0]  NUM_WORDS     = 2'h2;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [3:0]  wdata;
  } ccr_req_t;

  typedef enum logic {
    CCR_SRC_SLOW,
    CCR_SRC_FAST
  } ccr_src_t;
endpackage

// file: ccr_word.sv
// One 4-bit control word with read/write mask
`timescale 1ns/10ps
module ccr_word (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       we,
  input  wire logic [3:0] wdata,
  output logic [3:0]      q
);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= ccr_pkg::RESET_VALUE;
    end else if (we) begin
      q <= wdata & ccr_pkg::RW_MASK;
    end
  end
endmodule

// file: ccr_regs.sv
// Clock source and supply mode control registers
`timescale 1ns/10ps
module ccr_regs (
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire ccr_pkg::ccr_req_t req,
  output logic [3:0]           rdata,
  output logic                 cpu_clock_select,
  output logic                 fast_osc_enable,
  output logic                 core_voltage_select,
  output logic                 cpu_clk_fast,
  output logic                 doubler_enable,
  output logic                 regulator_source_select,
  output logic                 adc_source_select,
  output logic                 osc_regulator_voltage_high,
  output logic                 supply_mode_normal
);
  logic [3:0] clk_word;
  logic [3:0] sup_word;
  logic [1:0] we;
  logic [1:0] sel;
  logic [3:0] words [2];

  assign sel[0] = (req.addr == ccr_pkg::ADDR_CLK_OSC);
  assign sel[1] = (req.addr == ccr_pkg::ADDR_SUPPLY);
  assign clk_word = words[0];
  assign sup_word = words[1];

  genvar g;
  generate
    for (g = 0; g < ccr_pkg::NUM_WORDS; g++) begin : g_word
      assign we[g] = req.wr & sel[g];
      ccr_word u_word (
        .clk   (clk),
        .rst_n (rst_n),
        .we    (we[g]),
        .wdata (req.wdata),
        .q     (words[g])
      );
    end
  endgenerate

  // Read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 4'h0;
    end else if (req.rd && sel[0]) begin
      rdata <= words[0];
    end else if (req.rd && sel[1]) begin
      rdata <= words[1];
    end else begin
      rdata <= 4'h0;
    end
  end

  // Clock control outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cpu_clock_select    <= 1'b0;
      fast_osc_enable     <= 1'b0;
      core_voltage_select <= 1'b0;
    end else begin
      cpu_clock_select    <= clk_word[ccr_pkg::BIT_CPU_CLK];
      fast_osc_enable     <= clk_word[ccr_pkg::BIT_FAST_OSC];
      core_voltage_select <= clk_word[ccr_pkg::BIT_CORE_VSEL];
    end
  end

  // Fast CPU clock only when clock select and core voltage select are both set
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cpu_clk_fast <= 1'b0;
    end else begin
      cpu_clk_fast <= clk_word[ccr_pkg::BIT_CPU_CLK]
                      & clk_word[ccr_pkg::BIT_CORE_VSEL];
    end
  end

  // Compatibility bits, stored only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      doubler_enable          <= 1'b0;
      regulator_source_select <= 1'b0;
      adc_source_select       <= 1'b0;
    end else begin
      doubler_enable          <= sup_word[ccr_pkg::BIT_DOUBLER];
      regulator_source_select <= sup_word[ccr_pkg::BIT_REG_SRC];
      adc_source_select       <= sup_word[ccr_pkg::BIT_ADC_SRC];
    end
  end

  // Physical modes stay fixed whatever the compatibility bits hold
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      osc_regulator_voltage_high <= 1'b0;
      supply_mode_normal         <= 1'b1;
    end else begin
      osc_regulator_voltage_high <= 1'b0;
      supply_mode_normal         <= 1'b1;
    end
  end

  // Checks
  AST_UNUSED_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    clk_word[1] == 1'b0 && sup_word[1] == 1'b0)
    else $error("unused bit set");
  AST_CPU_CLK: assert property (@(posedge clk) disable iff (!rst_n)
    req.wr && sel[0] |=> ##1 cpu_clock_select == $past(req.wdata[3], 2))
    else $error("cpu clock select wrong");
  AST_FAST_OSC: assert property (@(posedge clk) disable iff (!rst_n)
    req.wr && sel[0] |=> ##1 fast_osc_enable == $past(req.wdata[2], 2))
    else $error("fast osc enable wrong");
  AST_CORE_VSEL: assert property (@(posedge clk) disable iff (!rst_n)
    req.wr && sel[0] |=> ##1 core_voltage_select == $past(req.wdata[0], 2))
    else $error("core voltage select wrong");
  AST_REG_FIXED: assert property (@(posedge clk) disable iff (!rst_n)
    !osc_regulator_voltage_high)
    else $error("regulator voltage moved");
  AST_MODE_NORMAL: assert property (@(posedge clk) disable iff (!rst_n)
    supply_mode_normal)
    else $error("supply mode left normal");
  AST_REG_SRC: assert property (@(posedge clk) disable iff (!rst_n)
    req.wr && sel[1] |=> ##1 regulator_source_select == $past(req.wdata[2], 2))
    else $error("regulator source select wrong");
  AST_ADC_SRC: assert property (@(posedge clk) disable iff (!rst_n)
    req.wr && sel[1] |=> ##1 adc_source_select == $past(req.wdata[3], 2))
    else $error("adc source select wrong");
  AST_READ_BACK: assert property (@(posedge clk) disable iff (!rst_n)
    req.rd && sel[0] |=> rdata == $past(clk_word))
    else $error("read data wrong");

  // Read path: second word, unmapped addresses and idle cycles
  AST_READ_BACK_SUP: assert property (@(posedge clk) disable iff (!rst_n)
    req.rd && sel[1] |=> rdata == $past(sup_word))
    else $error("supply word read data wrong");
  AST_READ_UNMAPPED: assert property (@(posedge clk) disable iff (!rst_n)
    req.rd && !sel[0] && !sel[1] |=> rdata == 4'h0)
    else $error("unmapped read not zero");
  AST_READ_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
    !req.rd |=> rdata == 4'h0)
    else $error("read data outside read cycle");
  AST_READ_BIT1: assert property (@(posedge clk) disable iff (!rst_n)
    req.rd |=> rdata[1] == 1'b0)
    else $error("unused bit read as one");

  // Word storage: writes land masked, other cycles hold
  AST_CLK_WORD_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    req.wr && sel[0] |=> clk_word == ($past(req.wdata) & ccr_pkg::RW_MASK))
    else $error("clock word write lost");
  AST_SUP_WORD_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    req.wr && sel[1] |=> sup_word == ($past(req.wdata) & ccr_pkg::RW_MASK))
    else $error("supply word write lost");
  AST_CLK_WORD_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    !(req.wr && sel[0]) |=> $stable(clk_word))
    else $error("clock word changed without write");
  AST_SUP_WORD_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    !(req.wr && sel[1]) |=> $stable(sup_word))
    else $error("supply word changed without write");
  AST_UNMAPPED_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    req.wr && !sel[0] && !sel[1] |=> $stable(clk_word) && $stable(sup_word))
    else $error("unmapped write changed a word");

  // Each control output follows its stored bit (the fast CPU clock both clock bits) one cycle later
  AST_CPU_CLK_FOLLOW: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> cpu_clock_select == $past(clk_word[ccr_pkg::BIT_CPU_CLK]))
    else $error("cpu clock select not following word");
  AST_FAST_OSC_FOLLOW: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> fast_osc_enable == $past(clk_word[ccr_pkg::BIT_FAST_OSC]))
    else $error("fast osc enable not following word");
  AST_CORE_VSEL_FOLLOW: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> core_voltage_select == $past(clk_word[ccr_pkg::BIT_CORE_VSEL]))
    else $error("core voltage select not following word");
  AST_CLK_FAST_FOLLOW: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> cpu_clk_fast == ($past(clk_word[ccr_pkg::BIT_CPU_CLK])
      & $past(clk_word[ccr_pkg::BIT_CORE_VSEL])))
    else $error("fast cpu clock not following both bits");
  AST_DOUBLER_FOLLOW: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> doubler_enable == $past(sup_word[ccr_pkg::BIT_DOUBLER]))
    else $error("doubler enable not following word");
  AST_REG_SRC_FOLLOW: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> regulator_source_select == $past(sup_word[ccr_pkg::BIT_REG_SRC]))
    else $error("regulator source select not following word");
  AST_ADC_SRC_FOLLOW: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) |-> adc_source_select == $past(sup_word[ccr_pkg::BIT_ADC_SRC]))
    else $error("adc source select not following word");
  AST_DOUBLER: assert property (@(posedge clk) disable iff (!rst_n)
    req.wr && sel[1] |=> ##1 doubler_enable == $past(req.wdata[ccr_pkg::BIT_DOUBLER], 2))
    else $error("doubler enable wrong");

  // Reset clears both words and every output except the fixed modes, which hold their values throughout
  AST_RESET_WORDS: assert property (@(posedge clk)
    !rst_n |=> clk_word == ccr_pkg::RESET_VALUE && sup_word == ccr_pkg::RESET_VALUE)
    else $error("words not cleared by reset");
  AST_RESET_OUTS: assert property (@(posedge clk)
    !rst_n |=> !cpu_clock_select && !fast_osc_enable && !core_voltage_select
      && !cpu_clk_fast && !doubler_enable && !regulator_source_select
      && !adc_source_select && rdata == 4'h0)
    else $error("outputs not cleared by reset");
  AST_RESET_MODES: assert property (@(posedge clk)
    !rst_n |=> supply_mode_normal && !osc_regulator_voltage_high)
    else $error("fixed modes lost in reset");

  // Per-bit view of both words: mapped bits take the written value, bit 1 stays clear
  genvar b;
  generate
    for (b = 0; b < $bits(ccr_pkg::RW_MASK); b++) begin : g_bit
      if (ccr_pkg::RW_MASK[b]) begin : g_rw
        AST_BIT_CLK: assert property (@(posedge clk) disable iff (!rst_n)
          req.wr && sel[0] |=> clk_word[b] == $past(req.wdata[b]))
          else $error("clock word bit not written");
        AST_BIT_SUP: assert property (@(posedge clk) disable iff (!rst_n)
          req.wr && sel[1] |=> sup_word[b] == $past(req.wdata[b]))
          else $error("supply word bit not written");
      end else begin : g_fixed
        AST_BIT_FIXED: assert property (@(posedge clk) disable iff (!rst_n)
          req.wr |=> clk_word[b] == 1'b0 && sup_word[b] == 1'b0)
          else $error("unused bit took a write");
      end
    end
  endgenerate
endmodule

// file: ccr_regs_test.sv
// Self-checking bench for the clock and supply control registers
`timescale 1ns/10ps
module ccr_regs_test;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  ccr_pkg::ccr_req_t req = '0;
  logic [3:0]        rdata;
  logic [8:0]        outs;
  logic [3:0]        m [2];
  int                fail_count = 0;
  int                check_count = 0;
  logic [15:0]       a;

  ccr_regs uut (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata),
    .cpu_clock_select(outs[8]), .fast_osc_enable(outs[7]), .core_voltage_select(outs[6]),
    .cpu_clk_fast(outs[5]), .doubler_enable(outs[4]), .regulator_source_select(outs[3]),
    .adc_source_select(outs[2]), .osc_regulator_voltage_high(outs[1]),
    .supply_mode_normal(outs[0]));

  always #10 clk = ~clk;

  task automatic compare(input string what, input logic [8:0] exp, input logic [8:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_outs();
    compare("outs", {m[0][3], m[0][2], m[0][0], m[0][3] & m[0][0], m[1][0], m[1][2],
      m[1][3], 2'b01}, outs);
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    m[0] = 4'h0;
    m[1] = 4'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    #1 check_outs();
    @(posedge clk);
  endtask

  task automatic write(input logic [15:0] ad, input logic [3:0] dt);
    req <= '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: dt};
    @(posedge clk);
    req <= '0;
    if (ad == ccr_pkg::ADDR_CLK_OSC) m[0] = dt & 4'hd;
    if (ad == ccr_pkg::ADDR_SUPPLY) m[1] = dt & 4'hd;
    @(posedge clk);
    #1 check_outs();
    @(posedge clk);
  endtask

  task automatic read(input logic [15:0] ad);
    req <= '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 4'h0};
    @(posedge clk);
    req <= '0;
    #1 compare("rdata", ad == ccr_pkg::ADDR_CLK_OSC ? m[0] :
      ad == ccr_pkg::ADDR_SUPPLY ? m[1] : 4'h0, rdata);
    @(posedge clk);
  endtask

  task automatic end_of_test();
    if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    end_of_test();
  end

  initial begin
    void'($urandom(32'h0272fbb5));
    do_reset();
    read(ccr_pkg::ADDR_CLK_OSC);
    read(ccr_pkg::ADDR_SUPPLY);
    write(ccr_pkg::ADDR_CLK_OSC, 4'hf);
    write(ccr_pkg::ADDR_SUPPLY, 4'hf);
    read(ccr_pkg::ADDR_CLK_OSC);
    read(ccr_pkg::ADDR_SUPPLY);
    for (int i = 0; i < 60; i++) begin
      a = ($urandom_range(3) == 3) ? 16'($urandom) :
        ccr_pkg::ADDR_CLK_OSC + 16'($urandom_range(1));
      write(a, 4'($urandom));
      read(ccr_pkg::ADDR_CLK_OSC + 16'($urandom_range(2)));
    end
    do_reset();
    read(ccr_pkg::ADDR_CLK_OSC);
    read(ccr_pkg::ADDR_SUPPLY);
    end_of_test();
  end
endmodule
